// >>> design/gpio_defines.vh
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH

// Data memory locations of latches and direction registers
`define ADDR_PORT_A_LATCH 8'h12
`define ADDR_PORT_A_DIR   8'h13
`define ADDR_PORT_B_LATCH 8'h14
`define ADDR_PORT_B_DIR   8'h15
`define ADDR_PORT_C_LATCH 8'h16
`define ADDR_PORT_C_DIR   8'h17
`define ADDR_PORT_D_LATCH 8'h18
`define ADDR_PORT_D_DIR   8'h19

// Reset values
`define DIR_RESET   8'hFF
`define LATCH_RESET 8'hFF
`define ZERO8       8'h00

// Shared pin positions
`define BIT_BZ      0
`define BIT_BZ_N    1
`define BIT_TONE    3

`endif

// >>> design/quad_port_io.v
`timescale 1ns/1ps
`include "gpio_defines.vh"

module quad_port_io #(
   parameter W = 8
) (
   input  wire         mclk,
   input  wire         nrst,
   input  wire [7:0]   mem_addr,
   input  wire         mem_wr,
   input  wire [W-1:0] mem_wdata,
   input  wire         mem_rd,
   output reg  [W-1:0] mem_rdata,
   output reg          mem_hit,
   input  wire [W-1:0] pad_a_in,
   input  wire [W-1:0] pad_b_in,
   input  wire [W-1:0] pad_c_in,
   input  wire [W-1:0] pad_d_in,
   output reg  [W-1:0] pad_a_out,
   output reg  [W-1:0] pad_b_out,
   output reg  [W-1:0] pad_c_out,
   output reg  [W-1:0] pad_d_out,
   output reg  [W-1:0] pad_a_oe,
   output reg  [W-1:0] pad_b_oe,
   output reg  [W-1:0] pad_c_oe,
   output reg  [W-1:0] pad_d_oe,
   output reg  [3:0]   pull_high_en,
   input  wire [3:0]   pull_high_opt,
   input  wire         tone_opt,
   input  wire         buzzer_opt,
   input  wire         pwm_opt,
   input  wire         timer_overflow,
   input  wire         buzzer_src,
   input  wire [3:0]   pwm_src,
   input  wire [W-1:0] port_b_analog,
   output reg          tone_divider_out,
   output reg          wake_req,
   output reg          ext_irq_in_0,
   output reg          ext_irq_in_1,
   output reg          timer_event_in_0,
   output reg          timer_event_in_1
);

   // ==================================================================
   // Register storage
   // ==================================================================
   reg [W-1:0] port_a_latch_q, port_b_latch_q;
   reg [W-1:0] port_c_latch_q, port_d_latch_q;
   reg [W-1:0] port_a_direction_q, port_b_direction_q;
   reg [W-1:0] port_c_direction_q, port_d_direction_q;
   reg         tone_q;
   reg [W-1:0] pa_prev_q;
   reg [W-1:0] rdata_d;
   reg         hit_d;
   reg [W-1:0] a_out_d, d_out_d, b_oe_d;

   // Latch and direction writes; latches hold until rewritten
   always @(posedge mclk) begin
      if (!nrst) begin
         port_a_latch_q     <= `LATCH_RESET;
         port_b_latch_q     <= `LATCH_RESET;
         port_c_latch_q     <= `LATCH_RESET;
         port_d_latch_q     <= `LATCH_RESET;
         port_a_direction_q <= `DIR_RESET;
         port_b_direction_q <= `DIR_RESET;
         port_c_direction_q <= `DIR_RESET;
         port_d_direction_q <= `DIR_RESET;
      end else if (mem_wr) begin
         // Read-modify-write is done by the core through rdata below
         case (mem_addr)
            `ADDR_PORT_A_LATCH: port_a_latch_q     <= mem_wdata;
            `ADDR_PORT_A_DIR:   port_a_direction_q <= mem_wdata;
            `ADDR_PORT_B_LATCH: port_b_latch_q     <= mem_wdata;
            `ADDR_PORT_B_DIR:   port_b_direction_q <= mem_wdata;
            `ADDR_PORT_C_LATCH: port_c_latch_q     <= mem_wdata;
            `ADDR_PORT_C_DIR:   port_c_direction_q <= mem_wdata;
            `ADDR_PORT_D_LATCH: port_d_latch_q     <= mem_wdata;
            `ADDR_PORT_D_DIR:   port_d_direction_q <= mem_wdata;
            default: ;
         endcase
      end
   end

   // ==================================================================
   // Read path
   // ==================================================================
   // Pad taken live, never latched; output lines return latch; analog B lines read 0
   always @* begin
      rdata_d = `ZERO8;
      hit_d   = 1'b1;
      case (mem_addr)
         `ADDR_PORT_A_LATCH: rdata_d = (port_a_direction_q & pad_a_in)
                               | (~port_a_direction_q & port_a_latch_q);
         `ADDR_PORT_B_LATCH: rdata_d = ((port_b_direction_q & pad_b_in)
                               | (~port_b_direction_q & port_b_latch_q))
                               & ~port_b_analog;
         `ADDR_PORT_C_LATCH: rdata_d = (port_c_direction_q & pad_c_in)
                               | (~port_c_direction_q & port_c_latch_q);
         `ADDR_PORT_D_LATCH: rdata_d = (port_d_direction_q & pad_d_in)
                               | (~port_d_direction_q & port_d_latch_q);
         `ADDR_PORT_A_DIR:   rdata_d = port_a_direction_q;
         `ADDR_PORT_B_DIR:   rdata_d = port_b_direction_q;
         `ADDR_PORT_C_DIR:   rdata_d = port_c_direction_q;
         `ADDR_PORT_D_DIR:   rdata_d = port_d_direction_q;
         default:            hit_d   = 1'b0;
      endcase
   end

   // ==================================================================
   // Pin output mux
   // ==================================================================
   // Shared functions gated by latch: latch 0 forces low
   always @* begin
      a_out_d = port_a_latch_q;
      if (tone_opt)
         a_out_d[`BIT_TONE] = port_a_latch_q[`BIT_TONE] & tone_q;
      if (buzzer_opt) begin
         a_out_d[`BIT_BZ]   = port_a_latch_q[`BIT_BZ] & buzzer_src;
         a_out_d[`BIT_BZ_N] = port_a_latch_q[`BIT_BZ_N]
                              & ~buzzer_src;
      end
      d_out_d = port_d_latch_q;
      if (pwm_opt)
         d_out_d[3:0] = port_d_latch_q[3:0] & pwm_src;
      // Analog lines never drive, whatever direction says
      b_oe_d = ~port_b_direction_q & ~port_b_analog;
   end

   // Tone divider: halves the overflow rate
   always @(posedge mclk) begin
      if (!nrst)
         tone_q <= 1'b0;
      else if (timer_overflow)
         tone_q <= ~tone_q;
   end

   // Registered outputs; oe follows direction, off on analog B lines, push-pull only
   always @(posedge mclk) begin
      if (!nrst) begin
         mem_rdata        <= `ZERO8;
         mem_hit          <= 1'b0;
         pad_a_out        <= `ZERO8;
         pad_b_out        <= `ZERO8;
         pad_c_out        <= `ZERO8;
         pad_d_out        <= `ZERO8;
         pad_a_oe         <= `ZERO8;
         pad_b_oe         <= `ZERO8;
         pad_c_oe         <= `ZERO8;
         pad_d_oe         <= `ZERO8;
         // Option is a mask setting, so pull-ups apply during reset too
         pull_high_en     <= pull_high_opt;
         tone_divider_out <= 1'b0;
         // Seed from the pad so release of reset is no false wake
         pa_prev_q        <= pad_a_in;
         wake_req         <= 1'b0;
         ext_irq_in_0     <= 1'b0;
         ext_irq_in_1     <= 1'b0;
         timer_event_in_0 <= 1'b0;
         timer_event_in_1 <= 1'b0;
      end else begin
         mem_rdata        <= mem_rd ? rdata_d : `ZERO8;
         mem_hit          <= mem_rd & hit_d;
         pad_a_out        <= a_out_d;
         pad_b_out        <= port_b_latch_q;
         pad_c_out        <= port_c_latch_q;
         pad_d_out        <= d_out_d;
         pad_a_oe         <= ~port_a_direction_q;
         pad_b_oe         <= b_oe_d;
         pad_c_oe         <= ~port_c_direction_q;
         pad_d_oe         <= ~port_d_direction_q;
         // Pull-high is per-port option; analog B lines handled by pad
         pull_high_en     <= pull_high_opt;
         tone_divider_out <= tone_q;
         // Any edge on an input-mode port A line requests wake
         pa_prev_q        <= pad_a_in;
         wake_req         <= |((pad_a_in ^ pa_prev_q)
                             & port_a_direction_q);
         // Pads always feed these inputs regardless of options
         ext_irq_in_0     <= pad_d_in[4];
         ext_irq_in_1     <= pad_d_in[5];
         timer_event_in_0 <= pad_d_in[6];
         timer_event_in_1 <= pad_d_in[7];
      end
   end

endmodule // quad_port_io

// >>> dv/board_pad.sv
`timescale 1ns/1ps
// ======
// Board side of one port
module board_pad (
   input  wire [7:0] oe,
   input  wire [7:0] out,
   input  wire       pull,
   input  wire [7:0] ext,
   output wire [7:0] pad
);
   // Undriven lines go high on pull, else take the bench level
   assign pad = (oe & out) | (~oe & ({8{pull}} | ext));
endmodule // board_pad

// >>> dv/quad_port_io_sva.sv
`timescale 1ns/1ps
// ======
// Port checker
module quad_port_io_sva #(
   parameter W = 8
) (
   input wire         mclk,
   input wire         nrst,
   input wire [7:0]   mem_addr,
   input wire         mem_rd,
   input wire         mem_wr,
   input wire [W-1:0] mem_rdata,
   input wire         mem_hit,
   input wire [W-1:0] pad_d_in,
   input wire [W-1:0] pad_b_oe,
   input wire [W-1:0] pad_c_out,
   input wire [W-1:0] pad_c_oe,
   input wire [3:0]   pull_high_en,
   input wire [3:0]   pull_high_opt,
   input wire         timer_overflow,
   input wire [W-1:0] port_b_analog,
   input wire         tone_divider_out,
   input wire         ext_irq_in_0,
   input wire         ext_irq_in_1,
   input wire         timer_event_in_0,
   input wire         timer_event_in_1
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // Mapped window of the port registers
   wire hit = mem_addr >= 8'h12 && mem_addr <= 8'h19;
   property p_hit; mem_rd && hit |=> mem_hit; endproperty
   a_hit: assert property (p_hit) else $error("no hit");
   property p_miss; mem_rd && !hit |=> !mem_hit && !mem_rdata; endproperty
   a_miss: assert property (p_miss) else $error("unmapped read");
   property p_idle; !mem_rd |=> mem_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("idle data");
   property p_pull; 1 |=> pull_high_en == $past(pull_high_opt); endproperty
   a_pull: assert property (p_pull) else $error("pull");
   property p_evt; 1 |=> {timer_event_in_1, timer_event_in_0,
      ext_irq_in_1, ext_irq_in_0} == $past(pad_d_in[7:4]); endproperty
   a_evt: assert property (p_evt) else $error("port d feed");
   property p_tone; 1 |=> tone_divider_out ==
      ($past(tone_divider_out) ^ $past(timer_overflow, 2)); endproperty
   a_tone: assert property (p_tone) else $error("tone");
   // Margin of four idle cycles covers the two-stage write path
   property p_hold; (nrst && !mem_wr) [*4] |->
      $stable(pad_c_out) && $stable(pad_c_oe); endproperty
   a_hold: assert property (p_hold) else $error("port c moved");
   property p_adc; (port_b_analog == 8'hFF) [*3] |-> !pad_b_oe; endproperty
   a_adc: assert property (p_adc) else $error("analog drive");
endmodule // quad_port_io_sva

// >>> dv/quad_port_io_with_pin_sharing_bench.sv
`timescale 1ns/1ps
// ======
// Bench for the four ports
module quad_port_io_with_pin_sharing_bench;
   reg        mclk = 1'h0, nrst = 1'h0, mem_wr = 1'h0, mem_rd = 1'h0;
   reg        tone_opt = 1'h0, buzzer_opt = 1'h0, pwm_opt = 1'h0;
   reg        timer_overflow = 1'h0, buzzer_src = 1'h0, woke = 1'h0;
   reg  [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, ext = 8'h3C, p, k;
   reg  [7:0] port_b_analog = 8'h00;
   reg  [3:0] pull_high_opt = 4'hF, pwm_src = 4'h0;
   wire [7:0] mem_rdata, pad_a_in, pad_b_in, pad_c_in, pad_d_in;
   wire [7:0] pad_a_out, pad_b_out, pad_c_out, pad_d_out;
   wire [7:0] pad_a_oe, pad_b_oe, pad_c_oe, pad_d_oe;
   wire [3:0] pull_high_en;
   wire       mem_hit, tone_divider_out, wake_req, ext_irq_in_0;
   wire       ext_irq_in_1, timer_event_in_0, timer_event_in_1;
   integer    bad_count = 0, samples_checked = 0;
   quad_port_io i_dut (.*);
   board_pad i_pa (.oe(pad_a_oe), .out(pad_a_out),
      .pull(pull_high_en[0]), .ext(ext), .pad(pad_a_in));
   board_pad i_pb (.oe(pad_b_oe), .out(pad_b_out),
      .pull(pull_high_en[1]), .ext(ext), .pad(pad_b_in));
   board_pad i_pc (.oe(pad_c_oe), .out(pad_c_out),
      .pull(pull_high_en[2]), .ext(ext), .pad(pad_c_in));
   board_pad i_pd (.oe(pad_d_oe), .out(pad_d_out),
      .pull(pull_high_en[3]), .ext(ext), .pad(pad_d_in));
   always #2 mclk = ~mclk;
   // Wake is a one-cycle pulse, so catch it here
   always @(posedge mclk) if (wake_req === 1'h1) woke <= 1'h1;
   task chk(input string n, input [7:0] s, input [7:0] e);
      samples_checked = samples_checked + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("BAD %0s exp %h seen %h", n, e, s);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(negedge mclk) {mem_addr, mem_wdata, mem_wr} = {a, d, 1'h1};
      @(negedge mclk) mem_wr = 1'h0;
   endtask
   // Read data stands one cycle, checked at the next falling edge
   task rd(input [7:0] a, input [7:0] e);
      @(negedge mclk) {mem_addr, mem_rd} = {a, 1'h1};
      @(negedge mclk) mem_rd = 1'h0;
      chk("rdata", mem_rdata, e);
   endtask
   task tick(input [7:0] n);
      repeat (n) @(negedge mclk);
   endtask
   task tally_and_finish;
      $display("checks %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      tick(2);
      nrst = 1'h1;
      for (p = 8'h12; p < 8'h1A; p = p + 8'h01) rd(p, 8'hFF);
      chk("oe", pad_a_oe | pad_b_oe | pad_c_oe | pad_d_oe, 8'h00);
      rd(8'h11, 8'h00);
      rd(8'h1A, 8'h00);
      pull_high_opt = 4'h0;
      for (p = 8'h00; p < 8'h08; p = p + 8'h02) begin
         wr(8'h12 + p, 8'hA5);
         wr(8'h13 + p, 8'hF0);
         rd(8'h12 + p, 8'h35);
      end
      tick(2);
      chk("oe", pad_a_oe & pad_b_oe & pad_c_oe & pad_d_oe, 8'h0F);
      chk("outc", pad_c_out & 8'h0F, 8'h05);
      pull_high_opt = 4'h4;
      rd(8'h16, 8'hF5);
      port_b_analog = 8'hFF;
      wr(8'h15, 8'h00);
      rd(8'h14, 8'h00);
      chk("oeb", pad_b_oe, 8'h00);
      {woke, ext} = {1'h0, 8'hC3};
      tick(3);
      chk("wake", {7'h00, woke}, 8'h01);
      chk("evt", {4'h0, timer_event_in_1, timer_event_in_0,
         ext_irq_in_1, ext_irq_in_0}, 8'h0C);
      {tone_opt, buzzer_opt, pwm_opt} = 3'h7;
      wr(8'h12, 8'h0B);
      rd(8'h18, 8'hC5);
      for (k = 8'h00; k < 8'h03; k = k + 8'h01) begin
         if (k == 8'h02) wr(8'h12, 8'h00);
         {buzzer_src, pwm_src} = {k[0], {4{k[0]}}};
         timer_overflow = 1'h1;
         tick(1);
         timer_overflow = 1'h0;
         tick(3);
         chk("pa", pad_a_out & 8'h0F, k[1] ? 8'h00 :
            (k[0] ? 8'h01 : 8'h0A));
         chk("pd", pad_d_out & 8'h0F, {5'h00, k[0], 1'h0, k[0]});
         chk("tone", {7'h00, tone_divider_out}, {7'h00, ~k[0]});
      end
      // Unused lines parked as outputs, so nothing floats
      port_b_analog = 8'h00;
      for (p = 8'h00; p < 8'h08; p = p + 8'h02)
         wr(8'h13 + p, 8'h00);
      tick(2);
      chk("oeall", pad_a_oe & pad_b_oe & pad_c_oe & pad_d_oe, 8'hFF);
      tally_and_finish;
   end
   // Run needs under a hundred cycles; the limit leaves wide margin
   initial begin
      #20000;
      bad_count = bad_count + 1;
      tally_and_finish;
   end
endmodule // quad_port_io_with_pin_sharing_bench
bind quad_port_io quad_port_io_sva #(.W(W)) i_sva (.*);
